/* File: core/saenc_defines.svh */
// register map, field positions, codes and timing counts of the serial encoder channel
// assumes: included by bare name from every design file that needs it
`ifndef SAENC_DEFINES_SVH
`define SAENC_DEFINES_SVH
// avalon word addresses
`define SAENC_ADDR_ENABLE 3'h0
`define SAENC_ADDR_CTRL 3'h1
`define SAENC_ADDR_CMD 3'h2
`define SAENC_ADDR_DATA_A 3'h3
`define SAENC_ADDR_DATA_B 3'h4
// shared link control fields
`define SAENC_CTRL_MDIV 31:24
`define SAENC_CTRL_NDIV 23:20
`define SAENC_CTRL_TRIG_SERVO 17
`define SAENC_CTRL_TRIG_FALL 16
`define SAENC_CTRL_TRIG_DELAY 15:8
`define SAENC_CTRL_PROTO 7:0
`define SAENC_CTRL_RESET 32'h00000000
// channel command fields
`define SAENC_CMD_DC_START 31
`define SAENC_CMD_ADDR 31:24
`define SAENC_CMD_CODE 23:16
`define SAENC_CMD_PARITY 15:14
`define SAENC_CMD_TRIG_MODE 13
`define SAENC_CMD_TRIG_ENA 12
`define SAENC_CMD_READY 10
`define SAENC_CMD_NBITS 5:0
`define SAENC_CMD_RESET 32'h00000000
// codes
`define SAENC_PROTO_CLOCKED 8'h03
`define SAENC_PROTO_PARAM 8'h04
`define SAENC_CODE_POSITION 8'h42
`define SAENC_CODE_STATUS 8'h50
`define SAENC_PAR_ODD 2'h1
`define SAENC_PAR_EVEN 2'h2
`define SAENC_POS_PAYLOAD 3'h4
`define SAENC_STATUS_PAYLOAD 3'h1
// timing and sizes
`define SAENC_OVERSAMPLE 5'h14
`define SAENC_MAX_POS_BITS 7'h30
`define SAENC_CRC_POLY 5'h0B
`define SAENC_TIMEOUT_TICKS 16'h0FA0
`endif

/* File: core/saenc_pkg.sv */
// state types of the serial encoder channel
// assumes: compiled before the channel modules
package saenc_pkg;
    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_TX = 2'b01,
        ENG_RX = 2'b10
    } saenc_eng_state_t;
    typedef enum logic [2:0] {
        CH_IDLE = 3'b000,
        CH_DELAY = 3'b001,
        CH_SEND = 3'b010,
        CH_RECV = 3'b011,
        CH_CLOCKED = 3'b100,
        CH_DONE = 3'b101
    } saenc_ch_state_t;
endpackage

/* File: core/saenc_char_engine.sv */
// half-duplex oversampled asynchronous character engine for the parameter channel
// assumes: tick is a one-cycle pulse at the oversample rate, lineIn already synchronised
`timescale 1ns/1ps
`include "saenc_defines.svh"
module saenc_char_engine #(
    parameter logic [4:0] OVS = `SAENC_OVERSAMPLE
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic tick,
    input wire logic txStart,
    input wire logic [7:0] txByte,
    input wire logic [1:0] paritySelect,
    input wire logic rxEnable,
    input wire logic lineIn,
    output logic lineOut,
    output logic lineOe,
    output logic txDone,
    output logic rxValid,
    output logic [7:0] rxByte,
    output logic rxBad
);
    saenc_pkg::saenc_eng_state_t state_q;
    logic [10:0] shift_q;
    logic [3:0] bitIdx_q;
    logic [4:0] sub_q;
    logic [7:0] data_q;
    logic par_q;
    logic parEna;
    logic [3:0] lastBit;

    function automatic logic parityOf(input logic [7:0] d, input logic [1:0] sel);
        return (sel == `SAENC_PAR_ODD) ? ~^d : ^d;
    endfunction

    assign parEna = (paritySelect == `SAENC_PAR_ODD) || (paritySelect == `SAENC_PAR_EVEN);
    assign lastBit = parEna ? 4'hA : 4'h9;

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= saenc_pkg::ENG_IDLE;
            shift_q <= 11'h7FF;
            bitIdx_q <= 4'h0;
            sub_q <= 5'h00;
            data_q <= 8'h00;
            par_q <= 1'b0;
            lineOut <= 1'b1;
            lineOe <= 1'b0;
            txDone <= 1'b0;
            rxValid <= 1'b0;
            rxByte <= 8'h00;
            rxBad <= 1'b0;
        end else begin
            txDone <= 1'b0;
            rxValid <= 1'b0;
            case (state_q)
                saenc_pkg::ENG_IDLE: begin
                    lineOe <= 1'b0;
                    lineOut <= 1'b1;
                    sub_q <= 5'h00;
                    bitIdx_q <= 4'h0;
                    if (txStart) begin
                        // start, data lsb first, optional parity, stop
                        shift_q <= parEna ? {1'b1, parityOf(txByte, paritySelect), txByte, 1'b0}
                                          : {2'b11, txByte, 1'b0};
                        lineOe <= 1'b1;
                        lineOut <= 1'b0;
                        state_q <= saenc_pkg::ENG_TX;
                    end else if (rxEnable && tick && !lineIn) begin
                        state_q <= saenc_pkg::ENG_RX;
                    end
                end
                saenc_pkg::ENG_TX: begin
                    if (tick) begin
                        if (sub_q == OVS - 5'h01) begin
                            sub_q <= 5'h00;
                            if (bitIdx_q == lastBit) begin
                                state_q <= saenc_pkg::ENG_IDLE;
                                txDone <= 1'b1;
                                lineOe <= 1'b0;
                                lineOut <= 1'b1;
                            end else begin
                                bitIdx_q <= bitIdx_q + 4'h1;
                                lineOut <= shift_q[1];
                                shift_q <= {1'b1, shift_q[10:1]};
                            end
                        end else begin
                            sub_q <= sub_q + 5'h01;
                        end
                    end
                end
                saenc_pkg::ENG_RX: begin
                    if (tick) begin
                        sub_q <= (sub_q == OVS - 5'h01) ? 5'h00 : sub_q + 5'h01;
                        if (sub_q == OVS - 5'h01) begin
                            bitIdx_q <= bitIdx_q + 4'h1;
                        end
                        // sample in the bit centre found from the oversampled start edge
                        if (sub_q == (OVS >> 1)) begin
                            if (bitIdx_q == 4'h0) begin
                                if (lineIn) begin
                                    state_q <= saenc_pkg::ENG_IDLE; // glitch, not a start bit
                                end
                            end else if (bitIdx_q == lastBit) begin
                                rxValid <= 1'b1;
                                rxByte <= data_q;
                                rxBad <= !lineIn || (parEna && (par_q != parityOf(data_q, paritySelect)));
                                state_q <= saenc_pkg::ENG_IDLE;
                            end else if (bitIdx_q == 4'h9) begin
                                par_q <= lineIn;
                            end else begin
                                data_q <= {lineIn, data_q[7:1]};
                            end
                        end
                    end
                end
                default: state_q <= saenc_pkg::ENG_IDLE;
            endcase
        end
    end
endmodule // saenc_char_engine

/* File: core/saenc_channel.sv */
// one channel of the serial absolute encoder interface with avalon-mm register slave
// assumes: phase and servo clocks and the data pair arrive asynchronously; one encoder per channel
`timescale 1ns/1ps
`include "saenc_defines.svh"
module saenc_channel (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic phaseClkIn,
    input wire logic servoClkIn,
    input wire logic linkDataIn,
    output logic linkDataOut,
    output logic linkDataOe,
    output logic linkClkOut
);
    saenc_pkg::saenc_ch_state_t state_q;
    logic waitReq_q;
    logic [31:0] readData_q;
    logic [31:0] rdMux;
    logic enable_q;
    logic [31:0] ctrl_q;
    logic [31:0] cmd_q;
    logic ready_q;
    logic [31:0] dataA_q;
    logic [31:0] dataB_q;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic trigPrev_q;
    logic [7:0] mCnt_q;
    logic [14:0] nCnt_q;
    logic serTick_q;
    logic [7:0] delayCnt_q;
    logic [2:0] byteIdx_q;
    logic [7:0] xsum_q;
    logic [15:0] toCnt_q;
    logic [47:0] pos_q;
    logic [7:0] errCode_q;
    logic fTo_q;
    logic fPar_q;
    logic fCs_q;
    logic fEnc_q;
    logic clkOut_q;
    logic [6:0] bitCnt_q;
    logic [4:0] crc_q;
    logic [4:0] crcRx_q;
    logic txStart_q;
    logic linkRst;
    logic wrAcc;
    logic [7:0] mDiv;
    logic mWrap;
    logic [15:0] nFull;
    logic [14:0] nLimit;
    logic trigSel;
    logic trigEdge;
    logic isParam;
    logic isClocked;
    logic [7:0] cmdCode;
    logic [7:0] txByte;
    logic [2:0] payload;
    logic [6:0] nEff;
    logic [47:0] posAligned;
    logic dIn;
    logic txDone;
    logic rxValid;
    logic [7:0] rxByte;
    logic rxBad;

    function automatic logic [4:0] crcNext(input logic [4:0] c, input logic b);
        return {c[3:0], 1'b0} ^ ((c[4] ^ b) ? `SAENC_CRC_POLY : 5'h00);
    endfunction

    assign linkRst = srst || !enable_q;
    assign wrAcc = avs_write && !waitReq_q;
    assign isParam = ctrl_q[`SAENC_CTRL_PROTO] == `SAENC_PROTO_PARAM;
    assign isClocked = ctrl_q[`SAENC_CTRL_PROTO] == `SAENC_PROTO_CLOCKED;
    assign cmdCode = cmd_q[`SAENC_CMD_CODE];
    assign dIn = sync2_q[2];

    // avalon slave: one wait state, then the access completes
    always_comb begin
        rdMux = 32'h00000000;
        case (avs_address)
            `SAENC_ADDR_ENABLE: rdMux = {31'h00000000, enable_q};
            `SAENC_ADDR_CTRL: rdMux = ctrl_q;
            `SAENC_ADDR_CMD: rdMux = {cmd_q[31:11], ready_q, cmd_q[9:0]};
            `SAENC_ADDR_DATA_A: rdMux = dataA_q;
            `SAENC_ADDR_DATA_B: rdMux = dataB_q;
            default: rdMux = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            waitReq_q <= 1'b1;
            readData_q <= 32'h00000000;
        end else if ((avs_read || avs_write) && waitReq_q) begin
            waitReq_q <= 1'b0;
            readData_q <= avs_read ? rdMux : readData_q;
        end else begin
            waitReq_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            enable_q <= 1'b0;
            ctrl_q <= `SAENC_CTRL_RESET;
        end else if (wrAcc) begin
            if (avs_address == `SAENC_ADDR_ENABLE) begin
                enable_q <= avs_writedata[0];
            end
            if (avs_address == `SAENC_ADDR_CTRL) begin
                ctrl_q <= avs_writedata;
            end
        end
    end

    // a software write in the completion cycle wins, so a fresh request is not lost
    always_ff @(posedge mclk) begin
        if (srst) begin
            cmd_q <= `SAENC_CMD_RESET;
        end else if (wrAcc && avs_address == `SAENC_ADDR_CMD) begin
            cmd_q <= avs_writedata;
        end else if (state_q == saenc_pkg::CH_DONE) begin
            if (cmd_q[`SAENC_CMD_TRIG_MODE]) begin
                cmd_q[`SAENC_CMD_TRIG_ENA] <= 1'b0;
            end
            if (isClocked) begin
                cmd_q[`SAENC_CMD_DC_START] <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (linkRst) begin
            ready_q <= 1'b0;
        end else if (state_q == saenc_pkg::CH_DONE) begin
            ready_q <= 1'b1;
        end else if (state_q == saenc_pkg::CH_DELAY) begin
            ready_q <= 1'b0;
        end
    end

    // pins cross into mclk through two flops
    always_ff @(posedge mclk) begin
        if (srst) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {linkDataIn, servoClkIn, phaseClkIn};
            sync2_q <= sync1_q;
        end
    end

    // two-stage serial clock divider
    assign mDiv = ctrl_q[`SAENC_CTRL_MDIV];
    assign mWrap = (mDiv <= 8'h01) || (mCnt_q == mDiv - 8'h01);
    assign nFull = 16'h0001 << ctrl_q[`SAENC_CTRL_NDIV];
    assign nLimit = nFull[14:0] - 15'h0001;

    always_ff @(posedge mclk) begin
        if (linkRst) begin
            mCnt_q <= 8'h00;
            nCnt_q <= 15'h0000;
            serTick_q <= 1'b0;
        end else begin
            serTick_q <= 1'b0;
            if (mWrap) begin
                mCnt_q <= 8'h00;
                if (nCnt_q == nLimit) begin
                    nCnt_q <= 15'h0000;
                    serTick_q <= 1'b1;
                end else begin
                    nCnt_q <= nCnt_q + 15'h0001;
                end
            end else begin
                mCnt_q <= mCnt_q + 8'h01;
            end
        end
    end

    // trigger from phase or servo clock, chosen edge
    assign trigSel = ctrl_q[`SAENC_CTRL_TRIG_SERVO] ? sync2_q[1] : sync2_q[0];
    assign trigEdge = ctrl_q[`SAENC_CTRL_TRIG_FALL] ? (trigPrev_q && !trigSel) : (!trigPrev_q && trigSel);

    always_ff @(posedge mclk) begin
        if (srst) begin
            trigPrev_q <= 1'b0;
        end else begin
            trigPrev_q <= trigSel;
        end
    end

    // address byte first, then command code; one encoder expected per channel
    assign txByte = (byteIdx_q == 3'h0) ? cmd_q[`SAENC_CMD_ADDR] : cmdCode;
    assign payload = (cmdCode == `SAENC_CODE_POSITION) ? `SAENC_POS_PAYLOAD
                   : (cmdCode == `SAENC_CODE_STATUS) ? `SAENC_STATUS_PAYLOAD : 3'h0;
    assign nEff = ({1'b0, cmd_q[`SAENC_CMD_NBITS]} > `SAENC_MAX_POS_BITS) ? `SAENC_MAX_POS_BITS
                : {1'b0, cmd_q[`SAENC_CMD_NBITS]};
    assign posAligned = pos_q >> (`SAENC_MAX_POS_BITS - nEff);

    always_ff @(posedge mclk) begin
        if (linkRst) begin
            state_q <= saenc_pkg::CH_IDLE;
            delayCnt_q <= 8'h00;
            byteIdx_q <= 3'h0;
            xsum_q <= 8'h00;
            toCnt_q <= 16'h0000;
            pos_q <= 48'h000000000000;
            errCode_q <= 8'h00;
            fTo_q <= 1'b0;
            fPar_q <= 1'b0;
            fCs_q <= 1'b0;
            fEnc_q <= 1'b0;
            clkOut_q <= 1'b1;
            bitCnt_q <= 7'h00;
            crc_q <= 5'h00;
            crcRx_q <= 5'h00;
            txStart_q <= 1'b0;
        end else begin
            txStart_q <= 1'b0;
            case (state_q)
                saenc_pkg::CH_IDLE: begin
                    // parameter channel runs only one-shot reads
                    if (trigEdge && cmd_q[`SAENC_CMD_TRIG_ENA] &&
                        (isClocked || (isParam && cmd_q[`SAENC_CMD_TRIG_MODE]))) begin
                        state_q <= saenc_pkg::CH_DELAY;
                        delayCnt_q <= 8'h00;
                        byteIdx_q <= 3'h0;
                        xsum_q <= 8'h00;
                        toCnt_q <= 16'h0000;
                        pos_q <= 48'h000000000000;
                        errCode_q <= 8'h00;
                        {fTo_q, fPar_q, fCs_q, fEnc_q} <= 4'h0;
                        bitCnt_q <= 7'h00;
                        crc_q <= 5'h00;
                    end
                end
                saenc_pkg::CH_DELAY: begin
                    if (delayCnt_q == ctrl_q[`SAENC_CTRL_TRIG_DELAY]) begin
                        state_q <= isParam ? saenc_pkg::CH_SEND : saenc_pkg::CH_CLOCKED;
                        txStart_q <= isParam;
                    end else if (serTick_q) begin
                        delayCnt_q <= delayCnt_q + 8'h01;
                    end
                end
                saenc_pkg::CH_SEND: begin
                    if (txDone) begin
                        if (byteIdx_q == 3'h0) begin
                            byteIdx_q <= 3'h1;
                            txStart_q <= 1'b1;
                        end else begin
                            state_q <= saenc_pkg::CH_RECV;
                            byteIdx_q <= 3'h0;
                            toCnt_q <= 16'h0000;
                        end
                    end
                end
                saenc_pkg::CH_RECV: begin
                    if (rxValid) begin
                        toCnt_q <= 16'h0000;
                        fPar_q <= fPar_q | rxBad;
                        xsum_q <= xsum_q ^ rxByte;
                        byteIdx_q <= byteIdx_q + 3'h1;
                        if (byteIdx_q == 3'h1 && rxByte != cmdCode) begin
                            fEnc_q <= 1'b1;
                        end
                        if (byteIdx_q >= 3'h2 && byteIdx_q < 3'h2 + payload) begin
                            pos_q <= (cmdCode == `SAENC_CODE_POSITION) ? {pos_q[39:0], rxByte} : pos_q;
                            errCode_q <= (cmdCode == `SAENC_CODE_STATUS) ? rxByte : errCode_q;
                        end
                        if (byteIdx_q == 3'h2 + payload) begin
                            fCs_q <= xsum_q != rxByte;
                            state_q <= saenc_pkg::CH_DONE;
                        end
                    end else if (serTick_q) begin
                        if (toCnt_q == `SAENC_TIMEOUT_TICKS) begin
                            fTo_q <= 1'b1;
                            state_q <= saenc_pkg::CH_DONE;
                        end else begin
                            toCnt_q <= toCnt_q + 16'h0001;
                        end
                    end
                end
                saenc_pkg::CH_CLOCKED: begin
                    if (serTick_q) begin
                        clkOut_q <= !clkOut_q;
                        // sample on each rising clock edge the channel drives
                        if (!clkOut_q) begin
                            if (bitCnt_q == 7'h00) begin
                                if (dIn) begin
                                    bitCnt_q <= 7'h01;
                                end else if (toCnt_q == `SAENC_TIMEOUT_TICKS) begin
                                    fTo_q <= 1'b1;
                                    state_q <= saenc_pkg::CH_DONE;
                                end else begin
                                    toCnt_q <= toCnt_q + 16'h0001;
                                end
                            end else begin
                                bitCnt_q <= bitCnt_q + 7'h01;
                                if (bitCnt_q == 7'h01) begin
                                    fEnc_q <= dIn;
                                    crc_q <= crcNext(crc_q, dIn);
                                end else if (bitCnt_q <= nEff + 7'h01) begin
                                    pos_q <= {dIn, pos_q[47:1]};
                                    crc_q <= crcNext(crc_q, dIn);
                                end else begin
                                    crcRx_q <= {crcRx_q[3:0], dIn};
                                    if (bitCnt_q == nEff + 7'h06) begin
                                        fCs_q <= {crcRx_q[3:0], dIn} != crc_q;
                                        state_q <= saenc_pkg::CH_DONE;
                                    end
                                end
                            end
                        end
                    end
                end
                saenc_pkg::CH_DONE: begin
                    clkOut_q <= 1'b1;
                    state_q <= saenc_pkg::CH_IDLE;
                end
                default: state_q <= saenc_pkg::CH_IDLE;
            endcase
        end
    end

    // data words are loaded once per completed transaction
    always_ff @(posedge mclk) begin
        if (srst) begin
            dataA_q <= 32'h00000000;
            dataB_q <= 32'h00000000;
        end else if (state_q == saenc_pkg::CH_DONE) begin
            if (isParam) begin
                dataA_q <= pos_q[31:0];
                dataB_q <= {fTo_q, fCs_q, fPar_q, fEnc_q, errCode_q, 20'h00000};
            end else begin
                dataA_q <= posAligned[31:0];
                dataB_q <= {fTo_q, fCs_q, fEnc_q, 13'h0000, posAligned[47:32]};
            end
        end
    end

    saenc_char_engine u_engine (
        .mclk(mclk),
        .srst(linkRst),
        .tick(serTick_q),
        .txStart(txStart_q),
        .txByte(txByte),
        .paritySelect(cmd_q[`SAENC_CMD_PARITY]),
        .rxEnable(state_q == saenc_pkg::CH_RECV),
        .lineIn(dIn),
        .lineOut(linkDataOut),
        .lineOe(linkDataOe),
        .txDone(txDone),
        .rxValid(rxValid),
        .rxByte(rxByte),
        .rxBad(rxBad)
    );

    assign avs_readdata = readData_q;
    assign avs_waitrequest = waitReq_q;
    assign linkClkOut = clkOut_q;
endmodule // saenc_channel

/* File: dv/saenc_channel_assertions.sv */
// port checker for one encoder channel
// assumes: bound to saenc_channel, one mclk domain
`timescale 1ns/1ps
module saenc_channel_assertions (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic linkDataOe,
    input wire logic linkDataOut,
    input wire logic linkClkOut
);
    logic enQ;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    always_ff @(posedge mclk) begin
        if (srst) enQ <= 1'b0;
        else if (avs_write && !avs_waitrequest && avs_address == 3'h0) enQ <= avs_writedata[0];
    end
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long answer");
    unmapped_zero_a: assert property (avs_read && avs_waitrequest && avs_address > 3'h4 |=> avs_readdata == 32'h0) else $error("hole read");
    rd_stable_a: assert property ($changed(avs_readdata) |-> !avs_waitrequest && $past(avs_read)) else $error("data moved");
    off_quiet_a: assert property (!enQ && !$past(enQ) |-> !linkDataOe) else $error("drives when off");
    off_clk_a: assert property (!enQ && !$past(enQ) |-> linkClkOut) else $error("clock when off");
    drive_min_a: assert property ($rose(linkDataOe) |-> linkDataOe [*8]) else $error("short drive");
    line_idle_a: assert property (!linkDataOe |-> linkDataOut) else $error("idle low");
    cover property (avs_read && !avs_waitrequest);
    cover property ($fell(linkDataOe));
    cover property ($fell(linkClkOut));
    cover property (enQ && avs_read && !avs_waitrequest && avs_readdata[10]);
endmodule // saenc_channel_assertions
bind saenc_channel saenc_channel_assertions chk (.*);

/* File: dv/saenc_encoder_model.sv */
// behavioural encoder on the data pair, 20 mclk a bit
// assumes: one tick per mclk, odd parity, pull-up on the pair
`timescale 1ns/1ps
module saenc_encoder_model #(
    parameter logic [31:0] POS = 32'h0000_0001,
    parameter logic [7:0] ERRC = 8'h01
) (
    input wire logic mclk,
    input wire logic txLevel,
    input wire logic txOe,
    input wire logic mute,
    output logic rxLevel,
    output logic [15:0] gotReq
);
    logic [7:0] sum;
    task automatic getc(output logic [7:0] b);
        while (!(txOe && !txLevel)) @(posedge mclk);
        repeat (30) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            b[i] = txLevel;
            repeat (20) @(posedge mclk);
        end
        repeat (20) @(posedge mclk);
    endtask
    task automatic putc(input logic [7:0] b);
        logic [10:0] f;
        f = {1'b1, ~^b, b, 1'b0};
        sum = sum ^ b;
        for (int i = 0; i < 11; i++) begin
            rxLevel <= f[i];
            repeat (20) @(posedge mclk);
        end
    endtask
    initial begin
        rxLevel = 1'b1;
        forever begin
            getc(gotReq[15:8]);
            getc(gotReq[7:0]);
            while (txOe) @(posedge mclk);
            repeat (40) @(posedge mclk);
            sum = 8'h00;
            if (!mute && (gotReq[15:8] == 8'h40 || gotReq[15:8] == 8'hFF)) begin
                putc(gotReq[15:8]);
                putc(gotReq[7:0]);
                if (gotReq[7:0] == 8'h42)
                    for (int i = 3; i >= 0; i--) putc(POS[8*i +: 8]);
                if (gotReq[7:0] == 8'h50) putc(ERRC);
                putc(sum);
            end
        end
    end
endmodule // saenc_encoder_model

/* File: dv/saenc_channel_test.sv */
// bench: register access, one-shot parameter-channel reads and one clocked-channel read
// assumes: encoder model on the pair, fast divider M=1 N=0
`timescale 1ns/1ps
`include "saenc_defines.svh"
module saenc_channel_test;
    localparam logic [31:0] POS = 32'h1D2E_3F40;
    localparam logic [7:0] ERRC = 8'h5A;
    logic mclk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, mute = 1'b0;
    logic phaseClkIn = 1'b0, servoClkIn = 1'b0, avs_waitrequest, linkDataOut, linkDataOe, linkClkOut, encLevel;
    logic [2:0] avs_address = 3'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic [15:0] gotReq;
    logic [7:0] codes [3] = '{8'h42, 8'h50, 8'h53};
    logic [31:0] expB [3] = '{32'h0, {4'h0, ERRC, 20'h0}, 32'h0};
    int n_errors = 0, samples_checked = 0, phCnt = 0, k;
    wire logic linkDataIn = linkDataOe ? linkDataOut : encLevel;
    saenc_channel uut (.*);
    saenc_encoder_model #(.POS(POS), .ERRC(ERRC)) enc (.mclk(mclk), .txLevel(linkDataIn), .txOe(linkDataOe),
        .mute(mute), .rxLevel(encLevel), .gotReq(gotReq));
    initial forever #50 mclk = ~mclk;
    always @(posedge mclk) begin
        phCnt <= phCnt + 1;
        phaseClkIn <= phCnt[4];
        servoClkIn <= phCnt[6];
    end
    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic [2:0] a, input logic w, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        for (int i = 0; i <= 40; i++) begin
            @(posedge mclk);
            if (avs_waitrequest === 1'b0) break;
            if (i == 40) chk(1'b0, 1'b1);
            if (i == 40) final_report;
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic run(input logic [7:0] code, input logic [31:0] b, input logic [5:0] nb);
        bus(`SAENC_ADDR_CMD, 1'b1, {8'h40, code, 4'h7, 6'h00, nb});
        for (k = 0; k < 4000; k++) begin
            bus(`SAENC_ADDR_CMD, 1'b0, 32'h0);
            if (q[12] === 1'b0 && q[10] === 1'b1) break;
        end
        if (k == 4000) chk(1'b0, 1'b1);
        if (k == 4000) final_report;
        chk(q, {8'h40, code, 4'h6, 6'h10, nb});
        bus(`SAENC_ADDR_DATA_B, 1'b0, 32'h0);
        chk(q, b);
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        bus(`SAENC_ADDR_CTRL, 1'b0, 32'h0);
        chk(q, 32'h0);
        // slow 961.5 baud setup only read back: the divider stays in reset until enabled
        bus(`SAENC_ADDR_CTRL, 1'b1, 32'h8223_0004);
        bus(`SAENC_ADDR_CTRL, 1'b0, 32'h0);
        chk(q, 32'h8223_0004);
        bus(3'h6, 1'b1, 32'hFFFF_FFFF);
        bus(3'h6, 1'b0, 32'h0);
        chk(q, 32'h0);
        bus(`SAENC_ADDR_CTRL, 1'b1, 32'h0100_0004);
        bus(`SAENC_ADDR_CMD, 1'b1, 32'h4042_7400);
        repeat (200) @(posedge mclk);
        bus(`SAENC_ADDR_CMD, 1'b0, 32'h0);
        chk(q, 32'h4042_7000);
        bus(`SAENC_ADDR_ENABLE, 1'b1, 32'h1);
        for (int i = 0; i < 3; i++) begin
            bus(`SAENC_ADDR_CTRL, 1'b1, {8'h01, 6'h0, i[0], i[1], 16'h0004});
            run(codes[i], expB[i], 6'h00);
            chk({16'h0, gotReq}, {16'h0, 8'h40, codes[i]});
            bus(`SAENC_ADDR_DATA_A, 1'b0, 32'h0);
            if (i == 0) chk(q, POS);
        end
        mute <= 1'b1;
        run(8'h42, 32'h8000_0000, 6'h00);
        bus(`SAENC_ADDR_CTRL, 1'b1, 32'h0100_0003);
        // idle-high line: encoder error bit set, all-ones position, crc field that cannot match
        run(8'h07, 32'h6000_0000, 6'h08);
        bus(`SAENC_ADDR_DATA_A, 1'b0, 32'h0);
        chk(q, 32'h0000_00FF);
        final_report;
    end
endmodule // saenc_channel_test
